// [companding_params.svh]
// Purpose: Constants for the companding and loopback unit.
// Assumes: Registers sit on word addresses of a classic Wishbone slave.
// Notes:   Included by the codec, the top module, the checker and the bench.
// How it works
// - Mu-law and A-law companding apply separately to transmit and receive.
// - Receive select bits 4:3: 00 off, 01 reserved, 10 mu-law, 11 A-law.
// - Transmit select bits 2:1: 00 off, 01 reserved, 10 mu-law, 11 A-law.
// - Packed bit forces an 8-bit interface word length.
// - Bit 6 loops receive interface output into transmit interface input.
// - Bit 0 loops ADC output data into the DAC data input.
// - After compression invert all bits for mu-law, even bits for A-law.
// - Companded byte sits in the top eight bits of the audio word.
// - Compress 14-bit linear for mu-law, 13-bit for A-law, into eight bits.
// - Eight segments give quiet samples finer steps than loud ones.
// - Word holds sign in bit 7, exponent 6:4, mantissa 3:0.
// - Segments follow the G.711 curves, mu 255 and A 87.6.
`ifndef COMPANDING_PARAMS_SVH
`define COMPANDING_PARAMS_SVH

`define CTRL_INDEX       4'h5
`define CTRL_ADDR        6'h14
`define WORD_LEN_ADDR    6'h18
`define CTRL_WIDTH       9
`define CTRL_RESET       9'h000
`define TX_LOOP_BIT      0
`define TX_SEL_LSB       1
`define RX_SEL_LSB       3
`define RX_LOOP_BIT      6
`define PACKED_BIT       7
`define WORD_LEN_RESET   2'h2
`define SAMPLE_WIDTH     16
`define MULAW_BIAS       14'h0021
`define ALAW_EVEN_MASK   8'h55
`define MULAW_ALL_MASK   8'hff

`endif

// [companding_pkg.sv]
// Purpose: Types shared by the companding unit.
// Assumes: Constants come from companding_params.svh.
// Notes:   Holds types only.
package companding_pkg;
  typedef enum logic [1:0] {
    LAW_OFF      = 2'b00,
    LAW_RESERVED = 2'b01,
    LAW_MU       = 2'b10,
    LAW_A        = 2'b11
  } law_type;

  // Interface word length codes: 16, 20, 24, 32 bits, plus the packed byte.
  typedef enum logic [2:0] {
    LEN_16 = 3'b000,
    LEN_20 = 3'b001,
    LEN_24 = 3'b010,
    LEN_32 = 3'b011,
    LEN_8  = 3'b100
  } word_len_type;
endpackage

// [law_codec.sv]
// Purpose: Combinational G.711 compressor and expander for one law.
// Assumes: Linear samples are 16-bit two's complement, left aligned.
// Notes:   Used once per direction by the top module.
`timescale 1ns/1ps
`include "companding_params.svh"
module law_codec
  import companding_pkg::*;
(
  // Selection
  input  wire logic       mu_i,
  // Compressor
  input  wire logic [15:0] lin_i,
  output logic      [7:0]  code_o,
  // Expander
  input  wire logic [7:0]  code_i,
  output logic      [15:0] lin_o
);
  // ==========================================================
  // Segment search
  // ==========================================================
  function automatic logic [2:0] seg_of(input logic [12:0] mag);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 0; i < 8; i++) begin
      if (mag[12:5] >> i != 8'h00) begin
        s = 3'(i);
      end
    end
    return s;
  endfunction

  // ==========================================================
  // Compressor
  // ==========================================================
  logic        sign;
  logic [13:0] mu_mag;
  logic [12:0] mu_biased;
  logic [11:0] a_mag;
  logic [2:0]  mu_seg;
  logic [2:0]  a_seg;
  logic [3:0]  mu_man;
  logic [3:0]  a_man;
  logic [7:0]  raw;

  assign sign   = lin_i[15];
  assign mu_mag = sign ? 14'(~lin_i[15:2]) : 14'(lin_i[15:2]);
  assign mu_biased = (mu_mag[12:0] > 13'h1fde) ? 13'h1fff
                   : 13'(mu_mag[12:0] + `MULAW_BIAS);
  assign a_mag  = sign ? 12'(~lin_i[14:3]) : lin_i[14:3];
  assign mu_seg = seg_of(mu_biased) ;
  // A-law segments sit one octave below the mu-law ones, so the magnitude is doubled for the search.
  assign a_seg  = seg_of({a_mag, 1'b0});
  // The shift is widened so that segment 7 does not wrap to a shift of zero.
  assign mu_man = 4'(mu_biased >> (4'(mu_seg) + 4'h1));
  assign a_man  = (a_seg == 3'h0) ? a_mag[4:1] : 4'(a_mag >> a_seg);
  // word layout
  // A mu-law sign reads one for positive only after inversion, an A-law sign before it.
  assign raw = mu_i ? {sign, mu_seg, mu_man} : {~sign, a_seg, a_man};
  assign code_o = raw ^ (mu_i ? `MULAW_ALL_MASK : `ALAW_EVEN_MASK);

  // ==========================================================
  // Expander
  // ==========================================================
  logic [7:0]  plain;
  logic [2:0]  e;
  logic [3:0]  m;
  logic [13:0] mu_lin;
  logic [12:0] a_lin;
  logic        neg;

  assign plain  = code_i ^ (mu_i ? `MULAW_ALL_MASK : `ALAW_EVEN_MASK);
  assign e      = plain[6:4];
  assign m      = plain[3:0];
  assign neg    = mu_i ? plain[7] : ~plain[7];
  assign mu_lin = 14'((({10'h000, m} << 1) + 14'h0021) << e) - 14'h0021;
  assign a_lin  = (e == 3'h0) ? 13'({m, 1'b1})
                : 13'(({9'h000, 1'b1, m, 1'b1}) << (e - 3'h1));
  assign lin_o  = mu_i ? (neg ? 16'(-{mu_lin, 2'b00}) : 16'({mu_lin, 2'b00}))
                       : (neg ? 16'(-{a_lin, 3'b000}) : 16'({a_lin, 3'b000}));
endmodule

// [audio_companding_loopback.sv]
// Purpose: Companding and digital loopback between audio interface and converters.
// Assumes: One 20 MHz clock, synchronous reset, classic Wishbone slave.
// Notes:   Samples move as valid-qualified 16-bit words, one per strobe.
`timescale 1ns/1ps
`include "companding_params.svh"
module audio_companding_loopback
  import companding_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // ADC side: converter sample in, serial interface word out
  input  wire logic        adc_valid_i,
  input  wire logic [15:0] adc_data_i,
  output logic             tx_valid_o,
  output logic      [15:0] tx_data_o,
  // Serial interface word in, DAC sample out
  input  wire logic        rx_valid_i,
  input  wire logic [15:0] rx_data_i,
  output logic             dac_valid_o,
  output logic      [15:0] dac_data_o,
  // Effective interface word length
  output word_len_type     interface_word_length_o
);
  // ==========================================================
  // Registers
  // ==========================================================
  logic [`CTRL_WIDTH-1:0] ctrl;
  logic [1:0]             word_len;
  logic                   hit_ctrl;
  logic                   hit_len;
  logic                   req;

  assign req      = cyc_i & stb_i & ~ack_o & ~err_o;
  assign hit_ctrl = adr_i == `CTRL_ADDR;
  assign hit_len  = adr_i == `WORD_LEN_ADDR;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl     <= `CTRL_RESET;
      word_len <= `WORD_LEN_RESET;
      ack_o    <= 1'b0;
      err_o    <= 1'b0;
      dat_o    <= 32'h00000000;
    end else if (ce_i) begin
      ack_o <= req & (hit_ctrl | hit_len);
      err_o <= req & ~(hit_ctrl | hit_len);
      if (req & we_i & hit_ctrl & sel_i[0]) begin
        ctrl[7:0] <= dat_i[7:0];
      end
      if (req & we_i & hit_ctrl & sel_i[1]) begin
        ctrl[8] <= dat_i[8];
      end
      if (req & we_i & hit_len & sel_i[0]) begin
        word_len <= dat_i[1:0];
      end
      dat_o <= hit_ctrl ? {23'h000000, ctrl} : hit_len ? {30'h00000000, word_len} : 32'h00000000;
    end
  end

  // ==========================================================
  // Field decode
  // ==========================================================
  law_type tx_law;
  law_type rx_law;
  logic    tx_loop;
  logic    rx_loop;
  logic    packed_byte_word_force;
  logic    tx_on;
  logic    rx_on;

  assign tx_law  = law_type'(ctrl[`TX_SEL_LSB+:2]);
  assign rx_law  = law_type'(ctrl[`RX_SEL_LSB+:2]);
  assign tx_loop = ctrl[`TX_LOOP_BIT];
  assign rx_loop = ctrl[`RX_LOOP_BIT];
  assign packed_byte_word_force = ctrl[`PACKED_BIT];
  assign tx_on = tx_law[1];
  assign rx_on = rx_law[1];

  assign interface_word_length_o = packed_byte_word_force ? LEN_8 : word_len_type'({1'b0, word_len});

  // ==========================================================
  // Codecs
  // ==========================================================
  logic [15:0] tx_src;
  logic        tx_src_valid;
  logic [7:0]  tx_code;
  logic [15:0] rx_lin;
  logic [15:0] rx_word;
  logic [15:0] tx_word;

  assign tx_src       = rx_loop ? rx_data_i : adc_data_i;
  assign tx_src_valid = rx_loop ? rx_valid_i : adc_valid_i;

  law_codec tx_codec (
    .mu_i   (tx_law == LAW_MU),
    .lin_i  (tx_src),
    .code_o (tx_code),
    .code_i (8'h00),
    .lin_o  ()
  );

  law_codec rx_codec (
    .mu_i   (rx_law == LAW_MU),
    .lin_i  (16'h0000),
    .code_o (),
    .code_i (rx_data_i[15:8]),
    .lin_o  (rx_lin)
  );

  assign tx_word = tx_on ? {tx_code, 8'h00} : tx_src;
  assign rx_word = rx_on ? rx_lin : rx_data_i;

  // ==========================================================
  // Output stages
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_valid_o  <= 1'b0;
      tx_data_o   <= 16'h0000;
      dac_valid_o <= 1'b0;
      dac_data_o  <= 16'h0000;
    end else if (ce_i) begin
      tx_valid_o <= tx_src_valid;
      if (tx_src_valid) begin
        tx_data_o <= tx_word;
      end
      dac_valid_o <= tx_loop ? adc_valid_i : rx_valid_i;
      if (tx_loop ? adc_valid_i : rx_valid_i) begin
        dac_data_o <= tx_loop ? adc_data_i : rx_word;
      end
    end
  end
endmodule

// [acl_sva.sv]
// Purpose: Port checker for the companding unit.
// Assumes: One clock, synchronous reset high.
// Notes:   Bound to the top module at the foot.
`timescale 1ns/1ps
`include "companding_params.svh"
module acl_sva
  import companding_pkg::*;
(
  // Clock and bus
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       cyc_i,
  input wire logic       stb_i,
  input wire logic       we_i,
  input wire logic [5:0] adr_i,
  input wire logic       ack_o,
  input wire logic       err_o,
  // Streams
  input wire logic       adc_valid_i,
  input wire logic       rx_valid_i,
  input wire logic       tx_valid_o,
  input wire logic       dac_valid_o,
  input word_len_type    interface_word_length_o
);
  // ==========================================
  // Assertions
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o) else $error("ack too long");
  bus_answer_a: assert property (cyc_i && stb_i && ce_i && !ack_o && !err_o |=> ack_o || err_o)
    else $error("no answer");
  err_unmapped_a: assert property (err_o |-> $past(adr_i) != `CTRL_ADDR && $past(adr_i) != `WORD_LEN_ADDR)
    else $error("err on mapped address");
  len_legal_a: assert property (interface_word_length_o inside {LEN_16, LEN_20, LEN_24, LEN_32, LEN_8})
    else $error("bad word length");
  len_write_a: assert property ($changed(interface_word_length_o) && !$past(rst_i) |-> ack_o && we_i)
    else $error("word length moved alone");
  tx_cause_a: assert property (tx_valid_o |-> $past(adc_valid_i) || $past(rx_valid_i))
    else $error("tx without input");
  dac_cause_a: assert property (dac_valid_o |-> $past(rx_valid_i) || $past(adc_valid_i))
    else $error("dac without input");
  reset_idle_a: assert property ($fell(rst_i) |-> !ack_o && !tx_valid_o && !dac_valid_o
    && interface_word_length_o == LEN_24) else $error("not idle after reset");
  cover property (err_o);
  cover property (tx_valid_o && interface_word_length_o == LEN_16);
  cover property (dac_valid_o && $past(adc_valid_i));
endmodule
bind audio_companding_loopback acl_sva i_sva (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .ack_o,
  .err_o, .adc_valid_i, .rx_valid_i, .tx_valid_o, .dac_valid_o, .interface_word_length_o);

// [acl_host.sv]
// Purpose: Serial interface host model.
// Assumes: Words are one-cycle valid strobes.
// Notes:   The data line shows the inverse word between frames.
`timescale 1ns/1ps
module acl_host (
  // Clock
  input  wire logic        clk_i,
  // Words from the unit
  input  wire logic        tx_valid_i,
  input  wire logic [15:0] tx_data_i,
  // Words to the unit
  output logic             rx_valid_o,
  output logic      [15:0] rx_data_o
);
  logic [15:0] got[$];
  initial rx_valid_o = 1'b0;
  initial rx_data_o = 16'h0000;
  always @(posedge clk_i) if (tx_valid_i) got.push_back(tx_data_i);
  task automatic send(input logic [15:0] w, input int gap);
    repeat (gap) @(posedge clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= w;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~w;
  endtask
endmodule

// [tb_top.sv]
// Purpose: Self-checking bench for the companding unit.
// Assumes: 20 MHz clock, reset held four cycles.
// Notes:   Codes are predicted by a model in this file.
`timescale 1ns/1ps
`include "companding_params.svh"
module tb_top
  import companding_pkg::*;
;
  logic         clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic         adc_valid_i = 1'b0, ack_o, err_o, tx_valid_o, rx_valid_i, dac_valid_o;
  logic [5:0]   adr_i = 6'h00;
  logic [3:0]   sel_i = 4'h0;
  logic [31:0]  dat_i = 32'h0, dat_o, seed = 32'h0000e086;
  logic [15:0]  adc_data_i = 16'h0000, tx_data_o, rx_data_i, dac_data_o, dq[$];
  word_len_type wl;
  int           err_total = 0, checks = 0;
  audio_companding_loopback i_dut (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .err_o, .adc_valid_i, .adc_data_i, .tx_valid_o, .tx_data_o, .rx_valid_i, .rx_data_i, .dac_valid_o,
    .dac_data_o, .interface_word_length_o(wl));
  acl_host i_host (.clk_i, .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .rx_valid_o(rx_valid_i),
    .rx_data_o(rx_data_i));
  always #25 clk_i = ~clk_i;
  always @(posedge clk_i) if (dac_valid_o) dq.push_back(dac_data_o);
  // ==========================================
  // Model and helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // The sign mask also carries the bit inversion of each law.
  function automatic logic [7:0] enc(input logic a, input logic [15:0] x);
    int p, g;
    logic [7:0] k;
    p = a ? $signed(x) >>> 3 : $signed(x) >>> 2;
    k = (p < 0) ? (a ? 8'h55 : 8'h7f) : (a ? 8'hd5 : 8'hff);
    if (p < 0) p = -p - 1;
    if (!a) p = (p + 33 > 8191) ? 8191 : p + 33;
    g = 0;
    while (g < 8 && p >= ((a ? 32 : 64) << g)) g++;
    if (g > 7) return 8'h7f ^ k;
    return {1'b0, g[2:0], 4'(p >> (a ? (g < 2 ? 1 : g) : g + 1))} ^ k;
  endfunction
  // Expected linear sample of a received code, on the 16-bit scale.
  function automatic logic [15:0] dec(input logic a, input logic [7:0] c);
    int t, e, m;
    logic [7:0] u;
    u = c ^ (a ? 8'h55 : 8'hff);
    e = u[6:4];
    m = u[3:0];
    if (a) t = (e == 0) ? 16 * m + 8 : (16 * m + 264) << (e - 1);
    else t = ((8 * m + 132) << e) - 132;
    return (a ? !u[7] : u[7]) ? 16'(-t) : 16'(t);
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic late();
    err_total++;
    $display("ERROR %0t timeout", $time);
    conclude();
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r,
                    output logic e);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'h3;
    dat_i <= d;
    for (int i = 0; i <= 20; i++) begin
      if (i == 20) late();
      @(posedge clk_i);
      if (ack_o || err_o) break;
    end
    r = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic take(input logic d, output logic [15:0] v);
    v = 16'hxxxx;
    for (int i = 0; i < 8; i++) begin
      if (d ? dq.size() > 0 : i_host.got.size() > 0) begin
        v = d ? dq.pop_front() : i_host.got.pop_front();
        return;
      end
      @(posedge clk_i);
    end
    late();
  endtask
  task automatic adc(input logic [15:0] v);
    @(posedge clk_i);
    adc_valid_i <= 1'b1;
    adc_data_i <= v;
    @(posedge clk_i);
    adc_valid_i <= 1'b0;
    adc_data_i <= ~v;
  endtask
  // ==========================================
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] v, w;
    logic        e;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `CTRL_ADDR, 32'h0, r, e);
    chk(r[8:0], `CTRL_RESET);
    chk(wl, LEN_24);
    wb(1'b0, 6'h3c, 32'h0, r, e);
    chk(e, 1'b1);
    wb(1'b1, `WORD_LEN_ADDR, 32'h0, r, e);
    wb(1'b1, `CTRL_ADDR, 32'h180, r, e);
    wb(1'b0, `CTRL_ADDR, 32'h0, r, e);
    chk(r[8:0], 9'h180);
    chk(wl, LEN_8);
    for (int k = 0; k < 4; k++) begin
      wb(1'b1, `CTRL_ADDR, 32'(k * 10), r, e);
      dq.delete();
      for (int n = 0; n < 6; n++) begin
        v = (n == 0) ? 16'h8000 : (n == 1) ? 16'h7fff : 16'(rnd());
        adc(v);
        take(1'b0, w);
        chk(w, k[1] ? {enc(k[0], v), 8'h00} : v);
        w = 16'(rnd());
        if (k == 2 && w[15:8] == 8'h7f) w[15:8] = 8'hff;
        i_host.send(w, n);
        v = 16'hxxxx;
        take(1'b1, v);
        if (k[1]) chk(v, dec(k[0], w[15:8]));
        if (k[1]) chk(enc(k[0], v), w[15:8]);
        else chk(v, w);
      end
    end
    wb(1'b1, `CTRL_ADDR, 32'h040, r, e);
    w = 16'(rnd());
    i_host.send(w, 0);
    take(1'b0, v);
    chk(v, w);
    wb(1'b1, `CTRL_ADDR, 32'h001, r, e);
    dq.delete();
    adc(w);
    v = 16'hxxxx;
    take(1'b1, v);
    chk(v, w);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `CTRL_ADDR, 32'h0, r, e);
    chk(r[8:0], `CTRL_RESET);
    chk(wl, LEN_24);
    conclude();
  end
endmodule
